/* testbench/iuc_config_sva.sv */
// Port assertions for the IDE timing and pin configuration block.
// Assumes one clock domain and binding onto every iuc_config instance.
`timescale 1ns/1ps
`default_nettype none
module iuc_config_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration access
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rdata_valid,
  // Timing and pads
  input wire logic [4:0] primary_drive0_strobe_cycle_time,
  input wire logic [4:0] primary_drive0_ready_to_stop_time,
  input wire logic [1:0] primary_drive0_base_clock,
  input wire logic primary_drive0_reserved_code,
  input wire logic [1:0] secondary_drive1_base_clock,
  input wire logic primary_pins_drive_low,
  input wire logic primary_pins_tristate,
  input wire logic primary_channel_enable,
  input wire logic secondary_pins_tristate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Reads answer exactly one cycle later, and only reads do
  a_read_answer: assert property (cfg_rd |=> cfg_rdata_valid)
    else $error("read not answered");
  a_valid_only_read: assert property (!cfg_rd |=> !cfg_rdata_valid)
    else $error("valid without read");
  a_unmapped_zero: assert property (
    cfg_rd && cfg_addr != 8'h48 && cfg_addr != 8'h54 |=> cfg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_rsvd_read_zero: assert property (cfg_rd && cfg_addr == 8'h54 |=>
    cfg_rdata[31:20] == 12'h000) else $error("reserved bits read nonzero");
  // Primary pads one-hot once the straps have landed
  a_pads_onehot: assert property ($past(resetn) |-> $onehot(
    {primary_pins_drive_low, primary_pins_tristate, primary_channel_enable}))
    else $error("primary pad controls not one-hot");
  // Timing pairs for each base clock; stop time tracks cycle time at 33 MHz
  a_timing_33: assert property ($past(resetn) && primary_drive0_base_clock == 2'h0 &&
    !primary_drive0_reserved_code |-> primary_drive0_strobe_cycle_time inside {5'h02, 5'h03,
    5'h04} && primary_drive0_ready_to_stop_time == primary_drive0_strobe_cycle_time + 5'h02)
    else $error("33 MHz timing pair wrong");
  a_timing_66: assert property (primary_drive0_base_clock == 2'h1 &&
    !primary_drive0_reserved_code |-> primary_drive0_ready_to_stop_time == 5'h08 &&
    primary_drive0_strobe_cycle_time inside {5'h02, 5'h03}) else $error("66 MHz pair wrong");
  a_timing_fast: assert property (primary_drive0_base_clock == 2'h2 &&
    !primary_drive0_reserved_code |-> primary_drive0_strobe_cycle_time == 5'h03 &&
    primary_drive0_ready_to_stop_time == 5'h10) else $error("fast timing pair wrong");
  // Writes reach the decoded outputs two edges later
  a_fast_override: assert property (cfg_wr && cfg_addr == 8'h54 && cfg_be[1] &&
    cfg_wdata[15] |-> ##2 secondary_drive1_base_clock == 2'h2)
    else $error("fast enable did not override");
  a_pin_normal: assert property (cfg_wr && cfg_addr == 8'h54 && cfg_be[2] &&
    cfg_wdata[17:16] == 2'h0 |-> ##2 primary_channel_enable) else $error("primary not enabled");
  a_sec_tristate: assert property (cfg_wr && cfg_addr == 8'h54 && cfg_be[2] &&
    cfg_wdata[19:18] == 2'h1 |-> ##2 secondary_pins_tristate) else $error("secondary not floated");
endmodule : iuc_config_sva

bind iuc_config iuc_config_sva iuc_config_sva_inst (.clk, .resetn, .cfg_addr, .cfg_wr, .cfg_rd,
  .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rdata_valid, .primary_drive0_strobe_cycle_time,
  .primary_drive0_ready_to_stop_time, .primary_drive0_base_clock, .primary_drive0_reserved_code,
  .secondary_drive1_base_clock, .primary_pins_drive_low, .primary_pins_tristate,
  .primary_channel_enable, .secondary_pins_tristate);
`default_nettype wire

/* testbench/iuc_host_model.sv */
// Host software model issuing configuration strobes at the falling edge.
// Assumes the block answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module iuc_host_model (
  // Clock
  input wire logic clk,
  // Requests
  output logic [7:0] cfg_addr,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  // Answers
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rdata_valid
);
  // Idle bus at time zero
  initial
  begin
    cfg_addr = 8'hFF;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end

  // One write; returns once decoded outputs settled. Reserved codes only on request
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_addr = ~a; // Released lines must not keep a stale value
    cfg_be = ~be;
    cfg_wdata = ~d;
    @(negedge clk);
  endtask : wr

  // One read; data and valid taken in the answer cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(negedge clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge clk);
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    d = cfg_rdata;
    v = cfg_rdata_valid;
  endtask : rd
endmodule : iuc_host_model
`default_nettype wire

/* testbench/test_ide_udma_timing_pin_config.sv */
// Self-checking bench for the IDE timing and pin configuration block.
// Assumes the host model drives all configuration strobes.
`timescale 1ns/1ps
`default_nettype none
module test_ide_udma_timing_pin_config;
  logic clk, resetn, primary_reset_tristate_strap, secondary_reset_tristate_strap;
  logic [7:0] cfg_addr;
  logic cfg_wr, cfg_rd, cfg_rdata_valid, rsv, pl, pt, pe, sl, st, se, vv;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rv;
  logic [4:0] ct, rp;
  logic [1:0] b0, b1, s0, s1;
  wire [7:0] bases = {s1, s0, b1, b0};
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  // Expected {cycle, stop, reserved} per base clock and code
  logic [10:0] exp_t [12] = '{11'h10C, 11'h0CA, 11'h088, 11'h001, 11'h001, 11'h0D0,
    11'h090, 11'h001, 11'h001, 11'h0E0, 11'h001, 11'h001};
  logic [2:0] pad_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h2}; // {low, float, enable}

  iuc_host_model iuc_host_model_inst (.clk, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_rdata_valid);
  iuc_config iuc_config_inst (.clk, .resetn, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_rdata_valid, .primary_reset_tristate_strap, .secondary_reset_tristate_strap,
    .primary_drive0_strobe_cycle_time(ct), .primary_drive0_ready_to_stop_time(rp),
    .primary_drive0_base_clock(b0), .primary_drive0_reserved_code(rsv),
    .primary_drive1_base_clock(b1), .secondary_drive0_base_clock(s0),
    .secondary_drive1_base_clock(s1), .primary_pins_drive_low(pl), .primary_pins_tristate(pt),
    .primary_channel_enable(pe), .secondary_pins_drive_low(sl), .secondary_pins_tristate(st),
    .secondary_channel_enable(se));

  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic w(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    iuc_host_model_inst.wr(a, be, d);
  endtask : w

  // Read must answer with valid and the expected word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    iuc_host_model_inst.rd(a, rv, vv);
    chk({31'h0, vv}, 32'h1);
    chk(rv, exp);
  endtask : rdchk

  // Reset held ten cycles with the given straps
  task automatic do_reset(input logic ps, input logic ss);
    @(negedge clk);
    resetn = 1'b0;
    primary_reset_tristate_strap = ps;
    secondary_reset_tristate_strap = ss;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset

  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    resetn = 1'b0;
    primary_reset_tristate_strap = 1'b0;
    secondary_reset_tristate_strap = 1'b0;
    do_reset(1'b1, 1'b0);
    rdchk(8'h54, 32'h0001_0000);
    chk({pt, se}, 2'h3);
    chk({ct, rp, b0, rsv}, {5'h04, 5'h06, 2'h0, 1'b0});
    rdchk(8'h48, 32'h0);
    do_reset(1'b0, 1'b1);
    rdchk(8'h54, 32'h0004_0000);
    chk({pe, st}, 2'h3);
    $display("test reset done");
    // Every code under every base clock; fast enable also overrides bit 0
    for (int i = 0; i < 12; i++)
    begin
      w(8'h54, 4'hF, (i < 4) ? 32'h0 : (i < 8) ? 32'h1 : 32'h1001);
      w(8'h48, 4'h1, i % 4);
      chk({ct, rp, rsv}, exp_t[i]);
      chk(b0, i / 4);
    end
    $display("test cycle codes done");
    // Every pin mode on both channels through byte lane 2 alone
    for (int m = 0; m < 4; m++)
    begin
      w(8'h54, 4'h4, {12'h0, m[1:0], ~m[1:0], 16'h0});
      rdchk(8'h54, {12'h0, m[1:0], ~m[1:0], 16'h1001});
      chk({pl, pt, pe}, pad_exp[~m[1:0]]);
      chk({sl, st, se}, pad_exp[m[1:0]]);
    end
    $display("test pin modes done");
    // Base select then fast enable per drive, others must stay at 33 MHz
    for (int d = 0; d < 4; d++)
    begin
      w(8'h54, 4'h3, 32'h1 << d);
      chk(bases, 8'h1 << (2 * d));
      w(8'h54, 4'h3, (32'h1 << d) | (32'h1000 << d));
      chk(bases, 8'h2 << (2 * d));
    end
    $display("test base clocks done");
    w(8'h54, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h54, 32'h000F_FFFF);
    w(8'h54, 4'h0, 32'h0);
    rdchk(8'h54, 32'h000F_FFFF);
    rdchk(8'h60, 32'h0);
    $display("test register map done");
    end_sim();
  end
endmodule : test_ide_udma_timing_pin_config
`default_nettype wire

/* verilog/iuc_config.sv */
// IDE Ultra DMA timing and pin configuration register block.
// Assumes configuration accesses arrive as one-cycle strobes on clk and that
// the reset-tristate straps come from companion-function logic on clk.
`timescale 1ns/1ps
`default_nettype none
module iuc_config (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration-space access
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rdata_valid,
  // Reset-tristate straps from the companion function
  input wire logic primary_reset_tristate_strap,
  input wire logic secondary_reset_tristate_strap,
  // Primary drive 0 timing to the channel timing generator
  output logic [4:0] primary_drive0_strobe_cycle_time,
  output logic [4:0] primary_drive0_ready_to_stop_time,
  output logic [1:0] primary_drive0_base_clock,
  output logic primary_drive0_reserved_code,
  // Effective base clock of the other drives
  output logic [1:0] primary_drive1_base_clock,
  output logic [1:0] secondary_drive0_base_clock,
  output logic [1:0] secondary_drive1_base_clock,
  // Primary pad control
  output logic primary_pins_drive_low,
  output logic primary_pins_tristate,
  output logic primary_channel_enable,
  // Secondary pad control
  output logic secondary_pins_drive_low,
  output logic secondary_pins_tristate,
  output logic secondary_channel_enable
);

  // All state of the block in one record
  typedef struct packed {
    iuc_pkg::iuc_state_t state;
    logic [19:0] cfg;
    logic [1:0] cycle0;
    logic [31:0] rdata;
    logic rvalid;
    logic [4:0] ct0;
    logic [4:0] rp0;
    logic [1:0] clk0;
    logic rsv0;
    logic [1:0] clk_p1;
    logic [1:0] clk_s0;
    logic [1:0] clk_s1;
    logic [2:0] pad_pri;
    logic [2:0] pad_sec;
  } iuc_regs_t;

  localparam iuc_regs_t REGS_RESET = '{
    state: iuc_pkg::ST_LOAD_STRAPS,
    cfg: iuc_pkg::IDE_IO_CONFIGURATION_RESET,
    cycle0: iuc_pkg::UDMA_TIMING_RESET,
    rdata: 32'h0000_0000,
    rvalid: 1'b0,
    ct0: 5'h00,
    rp0: 5'h00,
    clk0: 2'h0,
    rsv0: 1'b0,
    clk_p1: 2'h0,
    clk_s0: 2'h0,
    clk_s1: 2'h0,
    pad_pri: 3'h0,
    pad_sec: 3'h0
  };

  iuc_regs_t regs_ff;
  iuc_regs_t nxt_regs;

  logic [4:0] dec_ct;
  logic [4:0] dec_rp;
  logic [1:0] dec_clk;
  logic dec_rsv;
  logic [31:0] cfg_word;
  logic [31:0] timing_word;
  logic [31:0] byte_mask;

  // Timing decode for the primary master, the only drive whose cycle field is held here
  iuc_cycle_decode u_pd0_decode (
    .cycle_code(regs_ff.cycle0),
    .base_66(regs_ff.cfg[iuc_pkg::PRIMARY_DRIVE0_BASE_CLOCK_BIT]),
    .fast_enable(regs_ff.cfg[iuc_pkg::PRIMARY_DRIVE0_FAST_BIT]),
    .strobe_cycle_time(dec_ct),
    .ready_to_stop_time(dec_rp),
    .base_clock(dec_clk),
    .reserved_code(dec_rsv)
  );

  // Read views; reserved upper bits always read zero
  assign cfg_word = {12'h000, regs_ff.cfg};
  assign timing_word = {30'h0000_0000, regs_ff.cycle0};
  assign byte_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  // Effective base clock: fast bit wins, otherwise 0 is 33 MHz and 1 is 66 MHz
  function automatic logic [1:0] eff_clock(input logic base_66, input logic fast);
    logic [1:0] sel;
    sel = base_66 ? iuc_pkg::BASE_CLOCK_66 : iuc_pkg::BASE_CLOCK_33;
    if (fast)
    begin
      sel = iuc_pkg::BASE_CLOCK_133;
    end
    return sel;
  endfunction : eff_clock

  // Pad decode: {drive_low, tristate, channel_enable}
  function automatic logic [2:0] pad_decode(input logic [1:0] mode);
    logic [2:0] pad;
    case (mode)
      iuc_pkg::PIN_MODE_NORMAL: pad = 3'h1;
      iuc_pkg::PIN_MODE_TRISTATE: pad = 3'h2;
      iuc_pkg::PIN_MODE_DRIVE_LOW: pad = 3'h4;
      // Reserved code: keep the channel off rather than guess a drive level
      default: pad = 3'h2;
    endcase
    return pad;
  endfunction : pad_decode

  // Next-state logic for the whole block
  always_comb
  begin
    nxt_regs = regs_ff;
    nxt_regs.rvalid = 1'b0;
    case (regs_ff.state)
      iuc_pkg::ST_LOAD_STRAPS:
      begin
        // Straps are caught on the first edge after reset release, never under reset
        nxt_regs.cfg[iuc_pkg::SECONDARY_PIN_MODE_LSB +: 2] =
          secondary_reset_tristate_strap ? iuc_pkg::PIN_MODE_TRISTATE
                                         : iuc_pkg::PIN_MODE_NORMAL;
        nxt_regs.cfg[iuc_pkg::PRIMARY_PIN_MODE_LSB +: 2] =
          primary_reset_tristate_strap ? iuc_pkg::PIN_MODE_TRISTATE
                                       : iuc_pkg::PIN_MODE_NORMAL;
        nxt_regs.state = iuc_pkg::ST_RUN;
      end
      iuc_pkg::ST_RUN:
      begin
        nxt_regs.state = iuc_pkg::ST_RUN;
      end
      default:
      begin
        nxt_regs.state = iuc_pkg::ST_RUN;
      end
    endcase
    // A write in the strap cycle lands on top of the strap value
    if (cfg_wr)
    begin
      if (cfg_addr == iuc_pkg::IDE_IO_CONFIGURATION_OFS)
      begin
        nxt_regs.cfg = (nxt_regs.cfg & ~byte_mask[19:0]) |
                       (cfg_wdata[19:0] & byte_mask[19:0]);
      end
      else if (cfg_addr == iuc_pkg::UDMA_TIMING_OFS)
      begin
        if (cfg_be[0])
        begin
          nxt_regs.cycle0 = cfg_wdata[iuc_pkg::PRIMARY_DRIVE0_CYCLE_TIME_LSB +: 2];
        end
      end
    end
    // Reads answer one cycle later; unmapped offsets read zero
    if (cfg_rd)
    begin
      nxt_regs.rvalid = 1'b1;
      if (cfg_addr == iuc_pkg::IDE_IO_CONFIGURATION_OFS)
      begin
        nxt_regs.rdata = cfg_word;
      end
      else if (cfg_addr == iuc_pkg::UDMA_TIMING_OFS)
      begin
        nxt_regs.rdata = timing_word & iuc_pkg::UDMA_TIMING_MASK;
      end
      else
      begin
        nxt_regs.rdata = 32'h0000_0000;
      end
    end
    // Register the decoded timing so the generator sees glitch-free values
    nxt_regs.ct0 = dec_ct;
    nxt_regs.rp0 = dec_rp;
    nxt_regs.clk0 = dec_clk;
    nxt_regs.rsv0 = dec_rsv;
    nxt_regs.clk_p1 = eff_clock(regs_ff.cfg[iuc_pkg::PRIMARY_DRIVE1_BASE_CLOCK_BIT],
                                regs_ff.cfg[iuc_pkg::PRIMARY_DRIVE1_FAST_BIT]);
    nxt_regs.clk_s0 = eff_clock(regs_ff.cfg[iuc_pkg::SECONDARY_DRIVE0_BASE_CLOCK_BIT],
                                regs_ff.cfg[iuc_pkg::SECONDARY_DRIVE0_FAST_BIT]);
    nxt_regs.clk_s1 = eff_clock(regs_ff.cfg[iuc_pkg::SECONDARY_DRIVE1_BASE_CLOCK_BIT],
                                regs_ff.cfg[iuc_pkg::SECONDARY_DRIVE1_FAST_BIT]);
    // Pads leave the all-low reset value for tristate in the strap cycle, until the mode fields are settled
    if (regs_ff.state == iuc_pkg::ST_RUN)
    begin
      nxt_regs.pad_pri = pad_decode(regs_ff.cfg[iuc_pkg::PRIMARY_PIN_MODE_LSB +: 2]);
      nxt_regs.pad_sec = pad_decode(regs_ff.cfg[iuc_pkg::SECONDARY_PIN_MODE_LSB +: 2]);
    end
    else
    begin
      nxt_regs.pad_pri = 3'h2;
      nxt_regs.pad_sec = 3'h2;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      regs_ff <= REGS_RESET;
    end
    else
    begin
      regs_ff <= nxt_regs;
    end
  end

  // Outputs straight from the state record
  assign cfg_rdata = regs_ff.rdata;
  assign cfg_rdata_valid = regs_ff.rvalid;
  assign primary_drive0_strobe_cycle_time = regs_ff.ct0;
  assign primary_drive0_ready_to_stop_time = regs_ff.rp0;
  assign primary_drive0_base_clock = regs_ff.clk0;
  assign primary_drive0_reserved_code = regs_ff.rsv0;
  assign primary_drive1_base_clock = regs_ff.clk_p1;
  assign secondary_drive0_base_clock = regs_ff.clk_s0;
  assign secondary_drive1_base_clock = regs_ff.clk_s1;
  assign primary_pins_drive_low = regs_ff.pad_pri[2];
  assign primary_pins_tristate = regs_ff.pad_pri[1];
  assign primary_channel_enable = regs_ff.pad_pri[0];
  assign secondary_pins_drive_low = regs_ff.pad_sec[2];
  assign secondary_pins_tristate = regs_ff.pad_sec[1];
  assign secondary_channel_enable = regs_ff.pad_sec[0];

endmodule : iuc_config
`default_nettype wire

/* verilog/iuc_cycle_decode.sv */
// Decoder from an Ultra DMA cycle-time code and base clock to timing counts.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module iuc_cycle_decode (
  // Drive configuration
  input wire logic [1:0] cycle_code,
  input wire logic base_66,
  input wire logic fast_enable,
  // Decoded timing
  output logic [4:0] strobe_cycle_time,
  output logic [4:0] ready_to_stop_time,
  output logic [1:0] base_clock,
  output logic reserved_code
);

  // Fast enable takes precedence over the per-drive base select
  always_comb
  begin
    strobe_cycle_time = 5'h00;
    ready_to_stop_time = 5'h00;
    reserved_code = 1'b0;
    if (fast_enable)
    begin
      base_clock = iuc_pkg::BASE_CLOCK_133;
      // Only one legal code at the fastest clock
      if (cycle_code == iuc_pkg::CYCLE_CODE_01)
      begin
        strobe_cycle_time = iuc_pkg::CT_133_CODE01;
        ready_to_stop_time = iuc_pkg::RP_133_CODE01;
      end
      else
      begin
        reserved_code = 1'b1;
      end
    end
    else if (base_66)
    begin
      base_clock = iuc_pkg::BASE_CLOCK_66;
      case (cycle_code)
        iuc_pkg::CYCLE_CODE_01:
        begin
          strobe_cycle_time = iuc_pkg::CT_66_CODE01;
          ready_to_stop_time = iuc_pkg::RP_66_CODE01;
        end
        iuc_pkg::CYCLE_CODE_10:
        begin
          strobe_cycle_time = iuc_pkg::CT_66_CODE10;
          ready_to_stop_time = iuc_pkg::RP_66_CODE10;
        end
        default: reserved_code = 1'b1;
      endcase
    end
    else
    begin
      base_clock = iuc_pkg::BASE_CLOCK_33;
      case (cycle_code)
        iuc_pkg::CYCLE_CODE_00:
        begin
          strobe_cycle_time = iuc_pkg::CT_33_CODE00;
          ready_to_stop_time = iuc_pkg::RP_33_CODE00;
        end
        iuc_pkg::CYCLE_CODE_01:
        begin
          strobe_cycle_time = iuc_pkg::CT_33_CODE01;
          ready_to_stop_time = iuc_pkg::RP_33_CODE01;
        end
        iuc_pkg::CYCLE_CODE_10:
        begin
          strobe_cycle_time = iuc_pkg::CT_33_CODE10;
          ready_to_stop_time = iuc_pkg::RP_33_CODE10;
        end
        default: reserved_code = 1'b1;
      endcase
    end
  end

endmodule : iuc_cycle_decode
`default_nettype wire

/* verilog/iuc_pkg.sv */
// Constants for the IDE Ultra DMA timing and pin configuration block.
// Assumes a single host-side clock and 32-bit configuration-space accesses.
package iuc_pkg;

  // Configuration-space offsets (byte addresses, dword aligned)
  localparam logic [7:0] UDMA_TIMING_OFS = 8'h48;
  localparam logic [7:0] IDE_IO_CONFIGURATION_OFS = 8'h54;

  // Field positions in the udma timing register
  localparam int PRIMARY_DRIVE0_CYCLE_TIME_LSB = 0;
  localparam logic [31:0] UDMA_TIMING_MASK = 32'h0000_0003;
  localparam logic [1:0] UDMA_TIMING_RESET = 2'h0;

  // Field positions in the ide io configuration register
  localparam int PRIMARY_DRIVE0_BASE_CLOCK_BIT = 0;
  localparam int PRIMARY_DRIVE1_BASE_CLOCK_BIT = 1;
  localparam int SECONDARY_DRIVE0_BASE_CLOCK_BIT = 2;
  localparam int SECONDARY_DRIVE1_BASE_CLOCK_BIT = 3;
  localparam int PRIMARY_DRIVE0_FAST_BIT = 12;
  localparam int PRIMARY_DRIVE1_FAST_BIT = 13;
  localparam int SECONDARY_DRIVE0_FAST_BIT = 14;
  localparam int SECONDARY_DRIVE1_FAST_BIT = 15;
  localparam int PRIMARY_PIN_MODE_LSB = 16;
  localparam int SECONDARY_PIN_MODE_LSB = 18;
  localparam int CFG_STORED_BITS = 20;
  localparam logic [19:0] IDE_IO_CONFIGURATION_RESET = 20'h0_0000;

  // Pin mode encodings
  localparam logic [1:0] PIN_MODE_NORMAL = 2'h0;
  localparam logic [1:0] PIN_MODE_TRISTATE = 2'h1;
  localparam logic [1:0] PIN_MODE_DRIVE_LOW = 2'h2;

  // Cycle-time codes
  localparam logic [1:0] CYCLE_CODE_00 = 2'h0;
  localparam logic [1:0] CYCLE_CODE_01 = 2'h1;
  localparam logic [1:0] CYCLE_CODE_10 = 2'h2;

  // Timing counts in base clocks: strobe cycle time and ready-to-stop time
  localparam logic [4:0] CT_33_CODE00 = 5'h04;
  localparam logic [4:0] RP_33_CODE00 = 5'h06;
  localparam logic [4:0] CT_33_CODE01 = 5'h03;
  localparam logic [4:0] RP_33_CODE01 = 5'h05;
  localparam logic [4:0] CT_33_CODE10 = 5'h02;
  localparam logic [4:0] RP_33_CODE10 = 5'h04;
  localparam logic [4:0] CT_66_CODE01 = 5'h03;
  localparam logic [4:0] RP_66_CODE01 = 5'h08;
  localparam logic [4:0] CT_66_CODE10 = 5'h02;
  localparam logic [4:0] RP_66_CODE10 = 5'h08;
  localparam logic [4:0] CT_133_CODE01 = 5'h03;
  localparam logic [4:0] RP_133_CODE01 = 5'h10;

  // Effective base clock selection
  localparam logic [1:0] BASE_CLOCK_33 = 2'h0;
  localparam logic [1:0] BASE_CLOCK_66 = 2'h1;
  localparam logic [1:0] BASE_CLOCK_133 = 2'h2;

  // Block control states, one-hot
  typedef enum logic [1:0] {
    ST_LOAD_STRAPS = 2'b01,
    ST_RUN = 2'b10
  } iuc_state_t;

endpackage : iuc_pkg
